// ==== design/crps_device.sv ====
`timescale 1ns/10ps
// Summary of operation
// R1: system holds power-good low until supplies good
// R2: power-good rise followed by 1 ms reset
// R3: power-good high through boundary scan
// R4: hard reset invalidates L1 without writeback
// R5: reset held one millisecond after supply
// R6: bus outputs released within two clocks
// R7: soft-init at reset release runs self-test
// R8: fetch starts at power-on reset vector
// R9: deep-idle in clock-halt enters sleep
// R10: sleep gates all clocks except PLL
// R11: sleep ignores snoops and interrupts
// R12: deep-idle release returns to clock-halt
// R13: management interrupt saves state, enters mode
// R14: controller off: pins become irq, nmi
// R15: controller enabled after reset
// R16: clock-halt request enters halt, acknowledges
// R17: async sideband inputs pass two flops
// R18: one state machine, reset forces reset
module crps_device (
  input  wire logic        sys_clk,        // system bus clock
  input  wire logic        rst,            // local synchronous reset
  input  wire logic        clkEn,          // freezes all state while low
  crps_if.dev              link,           // chipset side
  input  wire logic        apicDisable,    // software: disable local controller
  input  wire logic        apicDisableWr,  // strobe for apicDisable
  input  wire logic        snoopReq,       // snoop request from bus unit
  input  wire logic        mgmtDone,       // management code finished (resume)
  input  wire logic        selftestDone,   // self-test completed
  output logic             coreClkEn,      // core clock gate
  output logic             busClkEn,       // bus and controller clock gate
  output logic             cacheInval,     // pulse: invalidate all L1 lines
  output logic             builtin_selftest, // self-test running
  output logic             fetchValid,     // fetch enabled
  output logic [31:0]      fetchAddr,      // first fetch address
  output logic             mgmt_mode,      // in management mode
  output logic             saveState,      // pulse: save state
  output logic             maskable_irq_req, // irq out, controller off
  output logic             nmiReq,         // nmi out, controller off
  output logic [1:0]       localIrq,       // local inputs, controller on
  output logic             snoopAck,       // snoop accepted
  output logic             local_irq_controller // controller enabled
);
  // sync bank: bit order per package positions
  logic [crps_pkg::SYNC_W-1:0] syncA_q;   // first stage, read only by second
  logic [crps_pkg::SYNC_W-1:0] syncB_q;   // second stage, safe to use
  wire  [crps_pkg::SYNC_W-1:0] rawIn = {link.local_irq_pins[1], link.local_irq_pins[0],
                                        ~link.mgmt_irq_n, ~link.clock_halt_req_n,
                                        ~link.deep_idle_req_n, link.supply_ok_in};

  // power-state bookkeeping; everything below freezes while clkEn is low
  crps_pkg::crps_state_t state_q;   // power state
  crps_pkg::crps_state_t state_d;   // next power state
  logic       hardRst_q;            // registered hard reset, for release edge
  logic       mgmtPrev_q;           // last management request level
  logic       mgmtSeen_q;           // management request pending
  logic [1:0] tx_q;                 // transaction being announced
  logic       apicEn_q;             // controller enable
  logic       builtin_selftest_q;               // self-test in progress
  logic       mgmt_q;               // management mode
  logic       save_q;               // save-state pulse
  logic       inval_q;              // invalidate pulse
  logic       fetch_q;              // fetching

  // decoded sideband levels, from second stage only
  wire supplyOk  = syncB_q[crps_pkg::SB_SUPPLY];
  wire idleReq   = syncB_q[crps_pkg::SB_IDLE];
  wire haltReq   = syncB_q[crps_pkg::SB_HALT];
  wire mgmtReq   = syncB_q[crps_pkg::SB_MGMT];
  // hard reset in effect: pin or power not good
  wire inReset   = link.hardReset | ~supplyOk;
  wire relEdge   = hardRst_q & ~inReset;       // reset release edge
  // sleep masks snoops and interrupts; only idle and reset still act
  wire inSleep   = (state_q == crps_pkg::CRPS_SLEEP);
  wire mgmtRise  = mgmtReq & ~mgmtPrev_q & ~inSleep;    // R11
  // a pending management request keeps the core running until it is served
  wire enterHalt = (state_q == crps_pkg::CRPS_RUN) & haltReq & ~mgmtSeen_q;

  // two-flop synchronisers for every async sideband input
  // reset leaves both stages at the idle level of every request
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      syncA_q <= '0;
      syncB_q <= '0;
    end else if (clkEn) begin
      syncA_q <= rawIn;    // R17
      syncB_q <= syncA_q;  // R17
    end
  end

  // next-state decode of the single power-state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      crps_pkg::CRPS_RESET: if (!builtin_selftest_q && fetch_q) state_d = crps_pkg::CRPS_RUN;
      // halt entry is announced on the bus at the same edge
      crps_pkg::CRPS_RUN:   if (enterHalt) state_d = crps_pkg::CRPS_HALT;  // R16
      crps_pkg::CRPS_HALT: begin
        if (idleReq) state_d = crps_pkg::CRPS_SLEEP;  // R9
        else if (!haltReq) state_d = crps_pkg::CRPS_RUN;
      end
      // only the deep-idle release or a hard reset leaves sleep; halt level is not read
      crps_pkg::CRPS_SLEEP: if (!idleReq) state_d = crps_pkg::CRPS_HALT;  // R12
      default: state_d = crps_pkg::CRPS_RESET;
    endcase
    // hard reset overrides whatever the case picked
    if (inReset) state_d = crps_pkg::CRPS_RESET;  // R18
  end

  // state register and reset bookkeeping
  // hardRst_q holds last cycle's reset level, for the entry and release edges
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q   <= crps_pkg::CRPS_RESET;
      // low, so the first hard reset after a local reset still invalidates
      hardRst_q <= 1'b0;
    end else if (clkEn) begin
      state_q   <= state_d;  // R18
      hardRst_q <= inReset;
    end
  end

  // reset side effects, self-test choice and fetch start
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      inval_q <= 1'b0;
      builtin_selftest_q  <= 1'b0;
      fetch_q <= 1'b0;
    end else if (clkEn) begin
      inval_q <= inReset & ~hardRst_q;           // R4
      // self-test choice is latched once, at the release edge
      if (inReset) begin
        builtin_selftest_q  <= 1'b0;
        fetch_q <= 1'b0;
        // released: soft-init level picks self-test or straight fetch
      end else if (relEdge) begin
        builtin_selftest_q  <= link.initReq;                 // R7
        fetch_q <= 1'b1;                         // R8
      end else if (builtin_selftest_q && selftestDone) begin
        builtin_selftest_q  <= 1'b0;
      end
    end
  end

  // management interrupt acceptance and bus announcements
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mgmtPrev_q <= 1'b0;
      mgmtSeen_q <= 1'b0;
      mgmt_q     <= 1'b0;
      save_q     <= 1'b0;
      tx_q       <= crps_pkg::CRPS_TX_NONE;
    end else if (clkEn) begin
      mgmtPrev_q <= mgmtReq;
      save_q     <= 1'b0;
      tx_q       <= crps_pkg::CRPS_TX_NONE;
      if (inReset) begin
        mgmtSeen_q <= 1'b0;
        mgmt_q     <= 1'b0;
      end else begin
        // accepted only while executing; a request in halt waits for run
        if (mgmtSeen_q && state_q == crps_pkg::CRPS_RUN && !mgmt_q) begin
          save_q     <= 1'b1;                    // R13
          mgmt_q     <= 1'b1;                    // R13
          mgmtSeen_q <= 1'b0;
          tx_q       <= crps_pkg::CRPS_TX_MGMT;  // R13
        end else if (enterHalt) begin
          tx_q       <= crps_pkg::CRPS_TX_HALT;  // R16
        end
        // placed last: a fresh request in the accepting cycle beats the clear
        if (mgmtRise) mgmtSeen_q <= 1'b1;
        // resume: the handler reports completion
        if (mgmt_q && mgmtDone) mgmt_q <= 1'b0;
      end
    end
  end

  // controller enable: software may switch it; reset brings it back on
  always_ff @(posedge sys_clk) begin
    if (rst) apicEn_q <= crps_pkg::LOCAL_IRQ_CONTROLLER_EN_RST;
    else if (clkEn) begin
      // a hard reset always returns the pins to local inputs
      if (inReset) apicEn_q <= crps_pkg::LOCAL_IRQ_CONTROLLER_EN_RST;  // R15
      else if (apicDisableWr) apicEn_q <= ~apicDisable;
    end
  end

  // pin roles follow the controller enable; sleep masks them all
  wire [1:0] lintSync = {syncB_q[crps_pkg::SB_LOCAL_IRQ_PIN1], syncB_q[crps_pkg::SB_LOCAL_IRQ_PIN0]};
  assign maskable_irq_req = ~apicEn_q & ~inSleep & lintSync[0];  // R14 R11
  assign nmiReq           = ~apicEn_q & ~inSleep & lintSync[1];  // R14 R11
  assign localIrq         = (apicEn_q & ~inSleep) ? lintSync : 2'h0;
  assign local_irq_controller = apicEn_q;
  // snoops are refused while asleep or in reset
  assign snoopAck         = snoopReq & ~inSleep & ~inReset;      // R11
  // clock gates: halt stops core only; sleep leaves only the PLL
  assign coreClkEn = (state_q == crps_pkg::CRPS_RUN) | (state_q == crps_pkg::CRPS_RESET);
  assign busClkEn  = ~inSleep;  // R10
  // bus outputs released in the same cycle reset is seen, inside the limit
  assign link.busOe    = ~inReset & ~hardRst_q & ~inSleep;  // R6
  assign link.busTx    = tx_q;
  assign link.pwrState = state_q;
  // registered outputs taken straight from their flops
  assign cacheInval       = inval_q;
  assign builtin_selftest = builtin_selftest_q;
  // fetch waits for self-test; the vector is fixed, not strapped
  assign fetchValid       = fetch_q & ~builtin_selftest_q & ~inReset;
  assign fetchAddr        = crps_pkg::RESET_VECTOR;  // R8
  assign mgmt_mode        = mgmt_q;
  assign saveState        = save_q;
endmodule

// ==== design/crps_pkg.sv ====
package crps_pkg;
  // power-state machine, gray coded along reset->run->halt->sleep
  typedef enum logic [1:0] {
    CRPS_RESET = 2'h0,
    CRPS_RUN   = 2'h1,
    CRPS_HALT  = 2'h3,
    CRPS_SLEEP = 2'h2
  } crps_state_t;

  // bus transaction codes the block announces
  typedef enum logic [1:0] {
    CRPS_TX_NONE = 2'h0,
    CRPS_TX_HALT = 2'h1,
    CRPS_TX_MGMT = 2'h2
  } crps_tx_t;

  localparam int unsigned CLK_MHZ       = 50;         // sys_clk rate
  localparam int unsigned RESET_US      = 1000;       // hard reset width, 1 ms
  localparam int unsigned RESET_CYCLES  = RESET_US * CLK_MHZ;  // 50000 cycles
  localparam int unsigned BUS_REL_CLKS  = 2;          // bus release limit after reset
  localparam logic [31:0] RESET_VECTOR  = 32'hFFFFFFF0;  // power-on fetch address
  localparam logic        LOCAL_IRQ_CONTROLLER_EN_RST   = 1'b1;       // controller enabled out of reset
  localparam int unsigned SYNC_W        = 6;          // width of sideband sync bank
  localparam int unsigned SB_SUPPLY     = 0;          // sync bank bit positions
  localparam int unsigned SB_IDLE       = 1;
  localparam int unsigned SB_HALT       = 2;
  localparam int unsigned SB_MGMT       = 3;
  localparam int unsigned SB_LOCAL_IRQ_PIN0      = 4;
  localparam int unsigned SB_LOCAL_IRQ_PIN1      = 5;
endpackage

// ==== design/crps_if.sv ====
`timescale 1ns/10ps
interface crps_if;
  logic hardReset;        // hard reset, active high
  logic supply_ok_in;     // power good
  logic initReq;          // soft-init, sampled at reset release
  logic deep_idle_req_n;  // sleep request, active low
  logic clock_halt_req_n; // clock-halt request, active low
  logic mgmt_irq_n;       // management interrupt, active low
  logic [1:0] local_irq_pins; // local interrupt pins
  logic busOe;            // device drives bus outputs
  logic [1:0] busTx;      // device bus transaction code, one cycle
  logic [1:0] pwrState;   // device power state
  modport dev (input hardReset, supply_ok_in, initReq, deep_idle_req_n, clock_halt_req_n,
               mgmt_irq_n, local_irq_pins, output busOe, busTx, pwrState);
  modport sys (output hardReset, supply_ok_in, initReq, deep_idle_req_n, clock_halt_req_n,
               mgmt_irq_n, local_irq_pins, input busOe, busTx, pwrState);
endinterface

// ==== design/crps_system.sv ====
`timescale 1ns/10ps
// chipset end: qualifies power good and stretches hard reset
module crps_system #(
  parameter int unsigned RESET_CYCLES = crps_pkg::RESET_CYCLES  // 1 ms default
) (
  input  wire logic  sys_clk,      // system bus clock
  input  wire logic  rst,          // synchronous reset
  input  wire logic  clkEn,        // freezes all state while low
  crps_if.sys        link,         // processor side
  input  wire logic  suppliesOk,   // supplies and clock within spec
  input  wire logic  scanActive,   // boundary scan in progress
  input  wire logic  initCfg,      // request self-test at next reset
  input  wire logic  idleCmd,      // ask for deep idle
  input  wire logic  haltCmd,      // ask for clock halt
  input  wire logic  mgmtCmd,      // raise management interrupt
  input  wire logic  [1:0] lintCmd, // local interrupt levels
  output logic       resetBusy,    // hard reset asserted
  output logic [1:0] devState      // processor power state
);
  logic        pgood_q;   // power good, glitch free from a flop
  logic [31:0] rstCnt_q;  // reset stretch counter

  // power good: low until supplies good, held high during scan
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pgood_q  <= 1'b0;
      rstCnt_q <= '0;
    end else if (clkEn) begin
      pgood_q <= suppliesOk | (pgood_q & scanActive);  // R1 R3
      // every fresh power good restarts the full reset width
      if (!pgood_q) rstCnt_q <= '0;                    // R2 R5
      else if (rstCnt_q != RESET_CYCLES) rstCnt_q <= rstCnt_q + 32'h1;
    end
  end

  assign link.supply_ok_in     = pgood_q;
  assign link.hardReset        = rstCnt_q != RESET_CYCLES;  // R2 R5
  assign link.initReq          = initCfg;
  assign link.deep_idle_req_n  = ~idleCmd;
  assign link.clock_halt_req_n = ~haltCmd;
  assign link.mgmt_irq_n       = ~mgmtCmd;
  assign link.local_irq_pins   = lintCmd;
  assign resetBusy             = link.hardReset;
  assign devState              = link.pwrState;
endmodule

// ==== tb/crps_properties.sv ====
`timescale 1ns/10ps
// link watcher; one clock domain, so clocking and reset are set once
module crps_properties (
  input logic       sys_clk,
  input logic       rst,
  input logic       hardReset,
  input logic       supply_ok_in,
  input logic       deep_idle_req_n,
  input logic       clock_halt_req_n,
  input logic       busOe,
  input logic [1:0] busTx,
  input logic [1:0] pwrState
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // bus let go soon after hard reset is seen
  property p_bus_off; hardReset |-> ##[0:2] !busOe; endproperty
  a_bus_off: assert property (p_bus_off) else $error("bus kept in reset");
  property p_rst_st; hardReset [*3] |-> pwrState == 2'h0; endproperty
  a_rst_st: assert property (p_rst_st) else $error("reset state missed");
  // stretch follows every rise of power good
  property p_rst_w; $rose(supply_ok_in) |-> hardReset [*8]; endproperty
  a_rst_w: assert property (p_rst_w) else $error("reset too short");
  // two sync flops: no halt on the next two edges
  property p_sync;
    $fell(clock_halt_req_n) && pwrState == 2'h1 |=> (pwrState != 2'h3) [*2];
  endproperty
  a_sync: assert property (p_sync) else $error("halt too early");
  property p_h_ack; pwrState == 2'h3 && $past(pwrState) == 2'h1 |-> ##[0:1] busTx == 2'h1; endproperty
  a_h_ack: assert property (p_h_ack) else $error("no halt ack");
  property p_no_idle; pwrState == 2'h1 |=> pwrState != 2'h2; endproperty
  a_no_idle: assert property (p_no_idle) else $error("slept from run");
  // sleep stops the bus unit, so nothing may be driven
  property p_quiet; pwrState == 2'h2 |-> !busOe && busTx == 2'h0; endproperty
  a_quiet: assert property (p_quiet) else $error("bus active in sleep");
  property p_wake; $rose(deep_idle_req_n) && pwrState == 2'h2 |-> ##[1:4] pwrState != 2'h2; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_m_ack; busTx == 2'h2 |-> pwrState == 2'h1; endproperty
  a_m_ack: assert property (p_m_ack) else $error("mgmt ack off run");
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/10ps
// chipset end and processor end joined by one link, driven from both user sides
module tb;
  localparam int RC = 20;  // short reset stretch keeps the run brief
  localparam logic [1:0] RUN = crps_pkg::CRPS_RUN, HALT = crps_pkg::CRPS_HALT;
  localparam logic [1:0] SLEEP = crps_pkg::CRPS_SLEEP;
  logic sys_clk = 1'b0, rst = 1'b1, clkEn = 1'b1;  // clock enable held on
  logic suppliesOk, scanActive, initCfg, idleCmd, haltCmd, mgmtCmd, apicDisable;
  logic apicDisableWr, snoopReq, mgmtDone, selftestDone, resetBusy, coreClkEn, busClkEn;
  logic cacheInval, builtin_selftest, fetchValid, mgmt_mode, saveState, maskable_irq_req;
  logic nmiReq, snoopAck, local_irq_controller;
  logic [1:0] lintCmd, devState, localIrq;
  logic [31:0] fetchAddr;
  int bad_count, checks_done, invals, saves, acks;  // tallies
  crps_if lk ();
  crps_system #(.RESET_CYCLES(RC)) crps_system_inst (.sys_clk(sys_clk), .rst(rst),
    .clkEn(clkEn), .link(lk), .suppliesOk(suppliesOk), .scanActive(scanActive),
    .initCfg(initCfg), .idleCmd(idleCmd), .haltCmd(haltCmd), .mgmtCmd(mgmtCmd),
    .lintCmd(lintCmd), .resetBusy(resetBusy), .devState(devState));
  crps_device crps_device_inst (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .link(lk),
    .apicDisable(apicDisable), .apicDisableWr(apicDisableWr), .snoopReq(snoopReq),
    .mgmtDone(mgmtDone), .selftestDone(selftestDone), .coreClkEn(coreClkEn),
    .busClkEn(busClkEn), .cacheInval(cacheInval), .builtin_selftest(builtin_selftest),
    .fetchValid(fetchValid), .fetchAddr(fetchAddr), .mgmt_mode(mgmt_mode),
    .saveState(saveState), .maskable_irq_req(maskable_irq_req), .nmiReq(nmiReq),
    .localIrq(localIrq), .snoopAck(snoopAck), .local_irq_controller(local_irq_controller));
  crps_properties crps_properties_inst (.sys_clk(sys_clk), .rst(rst), .hardReset(lk.hardReset),
    .supply_ok_in(lk.supply_ok_in), .deep_idle_req_n(lk.deep_idle_req_n),
    .clock_halt_req_n(lk.clock_halt_req_n), .busOe(lk.busOe), .busTx(lk.busTx),
    .pwrState(lk.pwrState));
  // clock and pulse counters; pulses last one cycle so they are tallied here
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    invals += (cacheInval === 1'b1);
    saves += (saveState === 1'b1);
    acks += (lk.busTx === 2'h2);
  end
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  // poll at falling edges, where outputs have settled
  task automatic wait_state(input logic [1:0] s);
    int n;
    n = 0;
    while (devState !== s && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    chk(devState === s, "state not reached");
  endtask
  // drop supplies, raise them, measure the hard reset that follows
  task automatic power_cycle(input logic init);
    int n, inv;
    n = 0;
    inv = invals;
    @(posedge sys_clk);
    suppliesOk <= 1'b0;
    initCfg <= init;
    repeat (6) @(negedge sys_clk);
    chk(resetBusy === 1'b1 && lk.busOe === 1'b0 && invals > inv, "reset entry");
    @(posedge sys_clk);
    suppliesOk <= 1'b1;
    while (resetBusy !== 1'b0 && n < RC + 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n >= RC && n < RC + 20, "reset width");
  endtask
  task automatic t_power_on;
    power_cycle(1'b0);
    wait_state(RUN);
    chk(fetchValid === 1'b1 && fetchAddr === crps_pkg::RESET_VECTOR, "fetch start");
    chk(builtin_selftest === 1'b0 && local_irq_controller === 1'b1, "reset config");
    $display("done power_on");
  endtask
  task automatic t_selftest;
    power_cycle(1'b1);
    @(negedge sys_clk);
    chk(builtin_selftest === 1'b1 && fetchValid === 1'b0, "self-test skipped");
    @(posedge sys_clk);
    selftestDone <= 1'b1;
    initCfg <= 1'b0;
    @(posedge sys_clk);
    selftestDone <= 1'b0;
    wait_state(RUN);
    @(negedge sys_clk);
    chk(fetchValid === 1'b1 && fetchAddr === crps_pkg::RESET_VECTOR, "fetch after test");
    $display("done selftest");
  endtask
  // deep idle refused in run, then halt, sleep, wake and management entry
  task automatic t_low_power;
    int s0;
    @(posedge sys_clk);
    idleCmd <= 1'b1;
    repeat (8) @(negedge sys_clk);
    chk(devState === RUN, "slept from run");
    @(posedge sys_clk);
    idleCmd <= 1'b0;
    haltCmd <= 1'b1;
    wait_state(HALT);
    chk(coreClkEn === 1'b0 && busClkEn === 1'b1, "halt clocks");
    @(posedge sys_clk);
    idleCmd <= 1'b1;
    wait_state(SLEEP);
    chk(busClkEn === 1'b0 && coreClkEn === 1'b0, "sleep clocks");
    @(posedge sys_clk);
    mgmtCmd <= 1'b1;
    snoopReq <= 1'b1;
    repeat (6) @(negedge sys_clk);
    chk(snoopAck === 1'b0 && mgmt_mode === 1'b0 && devState === SLEEP, "woke in sleep");
    @(posedge sys_clk);
    {snoopReq, idleCmd, mgmtCmd} <= 3'h0;
    wait_state(HALT);
    chk(busClkEn === 1'b1, "bus clock off");
    @(posedge sys_clk);
    haltCmd <= 1'b0;
    wait_state(RUN);
    s0 = saves;
    @(posedge sys_clk);
    mgmtCmd <= 1'b1;
    repeat (8) @(negedge sys_clk);
    chk(mgmt_mode === 1'b1 && saves == s0 + 1 && acks > 0, "mgmt entry");
    @(posedge sys_clk);
    {mgmtDone, mgmtCmd} <= 2'h2;
    @(posedge sys_clk);
    mgmtDone <= 1'b0;
    $display("done low_power");
  endtask
  task automatic t_lint;
    lintCmd <= 2'h1;
    repeat (5) @(negedge sys_clk);
    chk(localIrq === 2'h1 && maskable_irq_req === 1'b0, "local route");
    @(posedge sys_clk);
    {apicDisable, apicDisableWr, lintCmd} <= 4'hE;
    @(posedge sys_clk);
    apicDisableWr <= 1'b0;
    repeat (5) @(negedge sys_clk);
    chk(!local_irq_controller && nmiReq && !maskable_irq_req, "nmi route");
    @(posedge sys_clk);
    lintCmd <= 2'h1;
    repeat (5) @(negedge sys_clk);
    chk(maskable_irq_req === 1'b1 && nmiReq === 1'b0, "irq route");
    $display("done lint");
  endtask
  // supply dip during boundary scan must not reset; snoops served while running
  task automatic t_scan;
    @(posedge sys_clk);
    scanActive <= 1'b1;
    suppliesOk <= 1'b0;
    snoopReq <= 1'b1;
    repeat (6) @(negedge sys_clk);
    chk(resetBusy === 1'b0 && devState === RUN, "reset during scan");
    chk(snoopAck === 1'b1, "snoop refused in run");
    @(posedge sys_clk);
    {scanActive, suppliesOk, snoopReq} <= 3'h2;
    repeat (6) @(negedge sys_clk);
    chk(resetBusy === 1'b0 && devState === RUN, "reset after scan");
    $display("done scan");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // main sequence; scan stays idle until t_scan
  initial begin
    {suppliesOk, scanActive, initCfg, idleCmd, haltCmd, mgmtCmd, lintCmd} = '0;
    {apicDisable, apicDisableWr, snoopReq, mgmtDone, selftestDone} = '0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    t_power_on();
    t_selftest();
    t_low_power();
    t_lint();
    t_scan();
    complete_run();
  end
  // watchdog well past the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    complete_run();
  end
endmodule
